// ---- smi_pkg.sv ----
// Constants and types shared by the serial module I2C slave
package smi_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [2:0] OFS_MODE = 3'h0;
    localparam logic [2:0] OFS_STAT = 3'h1;
    localparam logic [2:0] OFS_OWN = 3'h2;
    localparam logic [2:0] OFS_DATA = 3'h3;
    localparam logic [2:0] OFS_TOUT = 3'h4;

    // ==========================================================
    // Field positions
    localparam int MODE_FSEL_LSB = 5;
    localparam int MODE_DEB_LSB = 2;
    localparam int MODE_EN = 1;
    localparam int MODE_ICF = 0;
    localparam int STAT_HCF = 7;
    localparam int STAT_ADDRESS_MATCH_FLAG = 6;
    localparam int STAT_HBB = 5;
    localparam int STAT_HTX = 4;
    localparam int STAT_TRANSMIT_ACK_BIT = 3;
    localparam int STAT_SRW = 2;
    localparam int STAT_MATCH_WAKEUP_ENABLE = 1;
    localparam int STAT_RECEIVE_ACK_FLAG = 0;
    localparam int IDX_SCL = 1;
    localparam int IDX_SDA = 0;

    // ==========================================================
    // Encodings, reset values and counts
    localparam logic [2:0] FSEL_I2C = 3'h6;
    localparam logic [2:0] FSEL_RST = 3'h7;
    localparam logic [1:0] DEB_NONE = 2'h0;
    localparam logic [1:0] DEB_TWO_SEL = 2'h1;
    localparam logic [2:0] DEB_TWO = 3'h2;
    localparam logic [2:0] DEB_FOUR = 3'h4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic HCF_RST = 1'b1;
    localparam logic RECEIVE_ACK_FLAG_RST = 1'b1;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        PH_IDLE,
        PH_ADDR,
        PH_ADDR_ACK,
        PH_RX,
        PH_RX_ACK,
        PH_TX,
        PH_TX_ACK,
        PH_HOLD,
        PH_WAIT_STOP
    } smi_phase_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smi_reg_req_t;

    typedef struct packed {
        logic [2:0] fsel;
        logic [1:0] deb;
        logic en;
        logic en_d;
        logic icf;
        logic transfer_complete_flag;
        logic address_match_flag;
        logic bus_busy_flag;
        logic transmit_select;
        logic transmit_ack_bit;
        logic master_direction_flag;
        logic match_wakeup_enable;
        logic receive_ack_flag;
        logic [7:0] own;
        logic [7:0] data;
        logic [7:0] tout;
        logic [7:0] rdata;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] filt;
        logic [1:0] fprev;
        logic [1:0][2:0] dcnt;
        smi_phase_t st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic sda_oe;
        logic scl_oe;
        logic drv_lvl;
        logic pins_en;
        logic irq;
        logic wake;
    } smi_state_t;

endpackage

// ---- smi_i2c_slave.sv ----
// I2C slave engine with its register file for the serial module
`timescale 1ns/1ps

// Overview of operation
// - Three-bit field selects module function
// - Debounce inputs: none, two or four clocks
// - Disabled module releases pins, stays idle
// - Enable rise resets flags, keeps select bits
// - Own address in bits 7..1, bit0 free
// - Selected only when address equals own address
// - One data register carries every data byte
// - Complete flag rises after byte, raises interrupt
// - Start and data read in receive mode clear; byte, stop set
// - Address match flag follows comparison result
// - Busy flag set by start, cleared by stop
// - Transmit select picks receiver or transmitter
// - Ninth clock drives transmit acknowledge bit
// - Direction flag stores address byte's last bit
// - Address match wakes device when enabled
// - Receive acknowledge flag records master response
// - Incomplete flag stored, unused in I2C mode
// - Start is SDA falling while SCL high
// - Acknowledge matched address on ninth clock
// - Release SDA when master does not acknowledge
module smi_i2c_slave
    import smi_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire smi_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    // Bus pins, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // System signals
    output logic pins_en_out,
    output logic irq_out,
    output logic wake_out
);

    // ==========================================================
    // State
    smi_state_t q;
    smi_state_t d;
    logic act;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic dacc;
    logic match;
    logic [2:0] need;

    assign act = q.en && q.en_d && (q.fsel == FSEL_I2C);
    assign scl_rise = q.filt[IDX_SCL] && !q.fprev[IDX_SCL];
    assign scl_fall = !q.filt[IDX_SCL] && q.fprev[IDX_SCL];
    assign start_det = q.filt[IDX_SCL] && q.fprev[IDX_SCL] && q.fprev[IDX_SDA]
        && !q.filt[IDX_SDA];
    assign stop_det = q.filt[IDX_SCL] && q.fprev[IDX_SCL] && !q.fprev[IDX_SDA]
        && q.filt[IDX_SDA];
    assign dacc = (reg_req_in.wr || reg_req_in.rd) && (reg_req_in.addr == OFS_DATA);
    assign match = (q.shift[7:1] == q.own[7:1]);
    assign need = (q.deb == DEB_NONE) ? 3'h0 : (q.deb == DEB_TWO_SEL) ? DEB_TWO : DEB_FOUR;

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] stat;
        logic [7:0] txb;
        stat = 8'h00;
        txb = 8'h00;
        d = q;
        d.irq = 1'b0;
        d.wake = 1'b0;
        d.rdata = 8'h00;
        d.en_d = q.en;
        // Pin synchronisers and debounce
        d.sync1 = {scl_in, sda_in};
        d.sync2 = q.sync1;
        d.fprev = q.filt;
        for (int i = 0; i < 2; i++) begin
            if (need == 3'h0) begin
                d.filt[i] = q.sync2[i];
                d.dcnt[i] = 3'h0;
            end else if (q.sync2[i] == q.filt[i]) begin
                d.dcnt[i] = 3'h0;
            end else if (q.dcnt[i] + 3'h1 >= need) begin
                d.filt[i] = q.sync2[i];
                d.dcnt[i] = 3'h0;
            end else begin
                d.dcnt[i] = q.dcnt[i] + 3'h1;
            end
        end
        // Register reads
        stat[STAT_HCF] = q.transfer_complete_flag;
        stat[STAT_ADDRESS_MATCH_FLAG] = q.address_match_flag;
        stat[STAT_HBB] = q.bus_busy_flag;
        stat[STAT_HTX] = q.transmit_select;
        stat[STAT_TRANSMIT_ACK_BIT] = q.transmit_ack_bit;
        stat[STAT_SRW] = q.master_direction_flag;
        stat[STAT_MATCH_WAKEUP_ENABLE] = q.match_wakeup_enable;
        stat[STAT_RECEIVE_ACK_FLAG] = q.receive_ack_flag;
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                OFS_MODE: d.rdata = {q.fsel, 1'b0, q.deb, q.en, q.icf};
                OFS_STAT: d.rdata = stat;
                OFS_OWN: d.rdata = q.own;
                OFS_DATA: d.rdata = q.data;
                OFS_TOUT: d.rdata = q.tout;
                default: d.rdata = 8'h00;
            endcase
            if (reg_req_in.addr == OFS_DATA && !q.transmit_select) begin
                d.transfer_complete_flag = 1'b0;
            end
        end
        // Register writes
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                OFS_MODE: begin
                    d.fsel = reg_req_in.wdata[MODE_FSEL_LSB +: 3];
                    d.deb = reg_req_in.wdata[MODE_DEB_LSB +: 2];
                    d.en = reg_req_in.wdata[MODE_EN];
                    d.icf = reg_req_in.wdata[MODE_ICF];
                end
                OFS_STAT: begin
                    d.transmit_select = reg_req_in.wdata[STAT_HTX];
                    d.transmit_ack_bit = reg_req_in.wdata[STAT_TRANSMIT_ACK_BIT];
                    d.match_wakeup_enable = reg_req_in.wdata[STAT_MATCH_WAKEUP_ENABLE];
                end
                OFS_OWN: d.own = reg_req_in.wdata;
                OFS_DATA: d.data = reg_req_in.wdata;
                OFS_TOUT: d.tout = reg_req_in.wdata;
                default: ;
            endcase
        end
        // Flag defaults when the module is switched on
        if (q.en && !q.en_d) begin
            d.transfer_complete_flag = HCF_RST;
            d.address_match_flag = 1'b0;
            d.bus_busy_flag = 1'b0;
            d.master_direction_flag = 1'b0;
            d.receive_ack_flag = RECEIVE_ACK_FLAG_RST;
        end
        // Bus engine
        if (!act) begin
            d.st = PH_IDLE;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else if (start_det) begin
            d.st = PH_ADDR;
            d.cnt = 4'h0;
            d.transfer_complete_flag = 1'b0;
            d.bus_busy_flag = 1'b1;
            d.address_match_flag = 1'b0;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else if (stop_det) begin
            d.st = PH_IDLE;
            d.bus_busy_flag = 1'b0;
            d.transfer_complete_flag = 1'b1;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else begin
            unique case (q.st)
                PH_ADDR: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], q.filt[IDX_SDA]};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                        if (match) begin
                            d.address_match_flag = 1'b1;
                            d.master_direction_flag = q.shift[0];
                            d.irq = 1'b1;
                            d.wake = q.match_wakeup_enable;
                            d.sda_oe = 1'b1;
                            d.st = PH_ADDR_ACK;
                        end else begin
                            d.address_match_flag = 1'b0;
                            d.st = PH_WAIT_STOP;
                        end
                    end
                end
                PH_ADDR_ACK, PH_RX_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.scl_oe = 1'b1;
                        d.st = PH_HOLD;
                    end
                end
                PH_HOLD: begin
                    if (dacc) begin
                        d.scl_oe = 1'b0;
                        d.cnt = 4'h0;
                        if (q.transmit_select) begin
                            txb = reg_req_in.wr ? reg_req_in.wdata : q.data;
                            d.shift = txb;
                            d.sda_oe = !txb[7];
                            d.st = PH_TX;
                        end else begin
                            d.st = PH_RX;
                        end
                    end
                end
                PH_RX: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], q.filt[IDX_SDA]};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                        d.data = q.shift;
                        d.transfer_complete_flag = 1'b1;
                        d.sda_oe = !q.transmit_ack_bit;
                        d.st = PH_RX_ACK;
                    end
                end
                PH_TX: begin
                    if (scl_rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            d.sda_oe = 1'b0;
                            d.transfer_complete_flag = 1'b1;
                            d.st = PH_TX_ACK;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sda_oe = !q.shift[6];
                        end
                    end
                end
                PH_TX_ACK: begin
                    if (scl_rise) begin
                        d.receive_ack_flag = q.filt[IDX_SDA];
                    end else if (scl_fall) begin
                        if (q.receive_ack_flag) begin
                            d.st = PH_WAIT_STOP;
                        end else begin
                            d.scl_oe = 1'b1;
                            d.st = PH_HOLD;
                        end
                    end
                end
                PH_IDLE, PH_WAIT_STOP: ;
            endcase
        end
        // A rising complete flag raises the interrupt
        if (d.transfer_complete_flag && !q.transfer_complete_flag) begin
            d.irq = 1'b1;
        end
        d.pins_en = d.en && (d.fsel == FSEL_I2C);
        d.drv_lvl = 1'b0;
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.fsel <= FSEL_RST;
            q.transfer_complete_flag <= HCF_RST;
            q.receive_ack_flag <= RECEIVE_ACK_FLAG_RST;
            q.data <= DATA_RST;
            q.sync1 <= 2'h3;
            q.sync2 <= 2'h3;
            q.filt <= 2'h3;
            q.fprev <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign scl_out = q.drv_lvl;
    assign scl_oe_out = q.scl_oe;
    assign sda_out = q.drv_lvl;
    assign sda_oe_out = q.sda_oe;
    assign pins_en_out = q.pins_en;
    assign irq_out = q.irq;
    assign wake_out = q.wake;

    // ==========================================================
    // Checks
    a_mode_pin_release: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (q.fsel != FSEL_I2C) |=> !scl_oe_out && !sda_oe_out)
        else $error("pins driven outside I2C mode");

    a_off_idle: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !q.en ##1 !q.en |-> !pins_en_out && q.st == PH_IDLE)
        else $error("disabled module still active");

    a_deb_glitch: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (q.deb != DEB_NONE && q.dcnt[IDX_SDA] == 3'h0
            && q.sync2[IDX_SDA] != q.filt[IDX_SDA])
        |=> q.filt[IDX_SDA] == $past(q.filt[IDX_SDA]))
        else $error("debounce passed a one-cycle change");

    a_enable_flags: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (q.en && !q.en_d && !reg_req_in.wr)
        |=> q.transfer_complete_flag && !q.address_match_flag && !q.bus_busy_flag && !q.master_direction_flag && q.receive_ack_flag
            && q.transmit_select == $past(q.transmit_select) && q.transmit_ack_bit == $past(q.transmit_ack_bit))
        else $error("flags not defaulted on enable");

    a_start_flags: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        act && start_det |=> !q.transfer_complete_flag && q.bus_busy_flag && q.st == PH_ADDR)
        else $error("start not handled");

    a_stop_flags: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        act && stop_det |=> q.transfer_complete_flag && !q.bus_busy_flag && !scl_oe_out && !sda_oe_out)
        else $error("stop not handled");

    a_addr_ack: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (act && q.st == PH_ADDR && scl_fall && q.cnt == BITS_PER_BYTE && match)
        |=> sda_oe_out && q.address_match_flag && irq_out && q.master_direction_flag == $past(q.shift[0]))
        else $error("matched address not acknowledged");

    a_addr_miss: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (act && q.st == PH_ADDR && scl_fall && q.cnt == BITS_PER_BYTE && !match)
        |=> !q.address_match_flag && !sda_oe_out && q.st == PH_WAIT_STOP)
        else $error("foreign address answered");

    a_wake_match: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wake_out |-> $past(q.match_wakeup_enable) && q.address_match_flag && $rose(q.address_match_flag))
        else $error("wake without enabled match");

    a_rx_ack_bit: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (act && q.st == PH_RX && scl_fall && q.cnt == BITS_PER_BYTE)
        |=> sda_oe_out == !$past(q.transmit_ack_bit) && q.transfer_complete_flag && q.data == $past(q.shift))
        else $error("received byte not acknowledged per setting");

    a_hcf_irq: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(q.transfer_complete_flag) |-> irq_out)
        else $error("complete flag rose without interrupt");

    a_hold_stretch: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (act && q.st == PH_HOLD && !dacc && !start_det && !stop_det)
        |=> scl_oe_out && q.st == PH_HOLD)
        else $error("clock released before data access");

    a_nack_release: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (act && q.st == PH_TX_ACK && scl_fall && q.receive_ack_flag)
        |=> !sda_oe_out && !scl_oe_out && q.st == PH_WAIT_STOP)
        else $error("SDA held after master nack");

    a_receive_ack_flag_sample: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (act && q.st == PH_TX_ACK && scl_rise)
        |=> q.receive_ack_flag == $past(q.filt[IDX_SDA]))
        else $error("master response not recorded");

endmodule // smi_i2c_slave

// ---- smi_bus_master.sv ----
// Behavioural I2C bus master that works the open-drain lines of the slave
`timescale 1ns/1ps
module smi_bus_master (
    // Clock
    input wire logic clk_in,
    // Resolved wire levels
    input wire logic scl_in,
    input wire logic sda_in,
    // Pull-downs, high pulls the line low
    output logic scl_low_out,
    output logic sda_low_out
);
    int half_clks = 20;

    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    // ==========================================
    // Line timing
    task automatic gap();
        repeat (half_clks) @(posedge clk_in);
    endtask

    // Releases SCL, then waits while the slave stretches it
    task automatic scl_up();
        int n;
        n = 0;
        scl_low_out <= 1'b0;
        @(posedge clk_in);
        while (scl_in !== 1'b1 && n < 4000) begin
            @(posedge clk_in);
            n++;
        end
        gap();
    endtask

    // ==========================================
    // Bus conditions and bytes
    task automatic start();
        sda_low_out <= 1'b0;
        scl_up();
        sda_low_out <= 1'b1;
        gap();
        scl_low_out <= 1'b1;
        gap();
    endtask

    task automatic stop();
        sda_low_out <= 1'b1;
        gap();
        scl_up();
        sda_low_out <= 1'b0;
        gap();
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low_out <= ~b;
        gap();
        scl_up();
        r = sda_in;
        scl_low_out <= 1'b1;
        gap();
    endtask

    // Eight bits then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
                        output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack, ack_seen);
    endtask
endmodule // smi_bus_master

// ---- serial_module_i2c_slave_regs_test.sv ----
// Self-checking bench for the serial module I2C slave
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module serial_module_i2c_slave_regs_test;
    import smi_pkg::*;

    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    smi_reg_req_t req = '0;
    logic [7:0] rdata;
    logic scl_o, scl_oe, sda_o, sda_oe, pins_en, irq, wake, m_scl, m_sda, scl_w, sda_w;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int irq_cnt = 0;
    int wake_cnt = 0;

    // Open-drain wires with pull-ups
    assign scl_w = ~((scl_oe & ~scl_o) | m_scl);
    assign sda_w = ~((sda_oe & ~sda_o) | m_sda);

    initial begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (irq === 1'b1) irq_cnt++;
        if (wake === 1'b1) wake_cnt++;
        if (cycles == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    smi_i2c_slave DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .pins_en_out(pins_en),
        .irq_out(irq), .wake_out(wake));

    smi_bus_master master (.clk_in(sys_clk_in), .scl_in(scl_w), .sda_in(sda_w),
        .scl_low_out(m_scl), .sda_low_out(m_sda));

    // ==========================================
    // Register port and expectations
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req <= '0;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] q);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req <= '0;
        #1;
        q = rdata;
    endtask

    task automatic reg_chk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        logic [7:0] q;
        reg_rd(a, q);
        `CHK(q & m, exp & m)
    endtask

    function automatic logic [7:0] st(input logic transfer_complete_flag, address_match_flag, bus_busy_flag, transmit_select, transmit_ack_bit, master_direction_flag, wu, receive_ack_flag);
        return {transfer_complete_flag, address_match_flag, bus_busy_flag, transmit_select, transmit_ack_bit, master_direction_flag, wu, receive_ack_flag};
    endfunction

    function automatic logic [7:0] mode(input logic [2:0] f, input logic [1:0] db, input logic en);
        return {f, 1'b0, db, en, 1'b0};
    endfunction

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [6:0] a;
        logic [7:0] d1, d2, q;
        logic ak, wu;
        int ic, wc;
        void'($urandom(91182));
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        reg_chk(OFS_MODE, 8'he0);
        reg_chk(OFS_STAT, 8'h81);
        reg_chk(OFS_OWN, 8'h00);
        for (int u = 5; u < 8; u++) begin
            reg_wr(3'(u), 8'hff);
            reg_chk(3'(u), 8'h00);
        end
        reg_wr(OFS_STAT, 8'hff);
        reg_chk(OFS_STAT, st(1, 0, 0, 1, 1, 0, 1, 1));
        reg_wr(OFS_STAT, 8'h00);
        reg_wr(OFS_TOUT, 8'h5a);
        reg_chk(OFS_TOUT, 8'h5a);
        d1 = 8'($urandom);
        a = d1[7:1];
        reg_wr(OFS_OWN, d1);
        reg_chk(OFS_OWN, d1);
        master.start();
        master.xfer({a, 1'b0}, 1'b1, q, ak);
        `CHK(ak, 1'b1)
        `CHK(pins_en, 1'b0)
        reg_chk(OFS_STAT, 8'h81);
        master.stop();
        reg_wr(OFS_MODE, mode(3'h5, 2'h0, 1'b1) | 8'h11);
        tick(2);
        `CHK(pins_en, 1'b0)
        reg_chk(OFS_MODE, 8'ha3);
        reg_wr(OFS_MODE, 8'he0);
        for (int dm = 0; dm < 4; dm++) begin
            wu = (dm == 2);
            // Off then on, so every pass starts from the enable defaults
            reg_wr(OFS_MODE, mode(FSEL_I2C, 2'(dm), 1'b0));
            reg_wr(OFS_MODE, mode(FSEL_I2C, 2'(dm), 1'b1));
            reg_wr(OFS_STAT, {6'h00, wu, 1'b0});
            tick(2);
            `CHK(pins_en, 1'b1)
            ic = irq_cnt;
            wc = wake_cnt;
            master.start();
            reg_chk(OFS_STAT, st(0, 0, 1, 0, 0, 0, wu, 1));
            master.xfer({a, 1'b0}, 1'b1, q, ak);
            `CHK(ak, 1'b0)
            `CHK(wake_cnt - wc, int'(wu))
            `CHK(irq_cnt - ic, 1)
            `CHK(scl_oe, 1'b1)
            reg_chk(OFS_STAT, st(0, 1, 1, 0, 0, 0, wu, 1));
            reg_rd(OFS_DATA, q);
            d1 = 8'($urandom);
            master.xfer(d1, 1'b1, q, ak);
            `CHK(ak, 1'b0)
            reg_chk(OFS_STAT, st(1, 1, 1, 0, 0, 0, wu, 1));
            reg_chk(OFS_DATA, d1);
            reg_chk(OFS_STAT, st(0, 1, 1, 0, 0, 0, wu, 1));
            reg_wr(OFS_STAT, {4'h0, 1'b1, 1'b0, wu, 1'b0});
            d2 = 8'($urandom);
            master.xfer(d2, 1'b1, q, ak);
            `CHK(ak, 1'b1)
            reg_chk(OFS_DATA, d2);
            master.stop();
            reg_chk(OFS_STAT, st(1, 0, 0, 0, 1, 0, wu, 1), 8'hbf);
            master.start();
            master.xfer({a, 1'b1}, 1'b1, q, ak);
            `CHK(ak, 1'b0)
            reg_chk(OFS_STAT, st(0, 1, 1, 0, 1, 1, wu, 1));
            reg_wr(OFS_STAT, {3'h0, 1'b1, 2'h0, wu, 1'b0});
            d1 = 8'($urandom);
            reg_wr(OFS_DATA, d1);
            master.xfer(8'hff, 1'b0, q, ak);
            `CHK(q, d1)
            `CHK(scl_oe, 1'b1)
            reg_chk(OFS_STAT, st(1, 1, 1, 1, 0, 1, wu, 0));
            d2 = 8'($urandom);
            reg_wr(OFS_DATA, d2);
            master.xfer(8'hff, 1'b1, q, ak);
            `CHK(q, d2)
            `CHK(sda_oe, 1'b0)
            reg_chk(OFS_STAT, st(1, 1, 1, 1, 0, 1, wu, 1));
            master.stop();
            reg_wr(OFS_STAT, {6'h00, wu, 1'b0});
            master.start();
            master.xfer({a ^ 7'h01, 1'b0}, 1'b1, q, ak);
            `CHK(ak, 1'b1)
            reg_chk(OFS_STAT, st(0, 0, 1, 0, 0, 0, wu, 1), 8'hfb);
            master.stop();
        end
        reg_wr(OFS_STAT, 8'h00);
        master.start();
        master.xfer({a, 1'b1}, 1'b1, q, ak);
        reg_wr(OFS_MODE, mode(FSEL_I2C, 2'h0, 1'b0));
        tick(2);
        `CHK(scl_oe, 1'b0)
        reg_wr(OFS_STAT, 8'h18);
        reg_wr(OFS_MODE, mode(FSEL_I2C, 2'h0, 1'b1));
        tick(2);
        reg_chk(OFS_STAT, st(1, 0, 0, 1, 1, 0, 0, 1));
        master.stop();
        tally_and_finish();
    end
endmodule // serial_module_i2c_slave_regs_test
